// >>> rtl/cati_pkg.sv
// Package with timing constants and state codes for the camera trigger and timing I/O block
package cati_pkg;
  // ==========================================
  // Timing
  localparam int CLK_HZ = 25000000;
  localparam int ECHO_TIME_NS = 6000;
  localparam int ECHO_CYCLES_INT = (ECHO_TIME_NS * (CLK_HZ / 1000000)) / 1000;
  localparam logic [7:0] ECHO_CYCLES = ECHO_CYCLES_INT[7:0];
  localparam logic [7:0] ECHO_CNT_RST = 8'h00;
  // ==========================================
  // Trigger sources
  localparam int NUM_SRC = 3;
  localparam logic [2:0] SYNC_RST = 3'h7;
  // ==========================================
  // Echo pulse states
  typedef enum logic [1:0] {
    CATI_IDLE = 2'b01,
    CATI_PULSE = 2'b10
  } cati_echo_t;
endpackage

// >>> rtl/cati_trig_if.sv
// Interface carrying trigger events between the edge detector and the main logic
`timescale 1ns/100ps
interface cati_trig_if;
  logic [2:0] raw;
  logic fire;
  logic [2:0] which;
  modport det (input raw, output fire, output which);
  modport top (output raw, input fire, input which);
endinterface

// >>> rtl/cati_edge_det.sv
// Synchroniser and falling-edge detector for the three trigger sources
`timescale 1ns/100ps
module cati_edge_det (
  // Clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Trigger lines
  cati_trig_if.det trig
);
  // ==========================================
  // Two-stage synchroniser, then one history stage for edge detection
  logic [2:0] meta;
  logic [2:0] sync;
  logic [2:0] hist;
  wire [2:0] fall;

  genvar g;
  generate
    for (g = 0; g < cati_pkg::NUM_SRC; g++) begin : g_src
      always_ff @(posedge clk) begin
        if (srst) begin
          meta[g] <= cati_pkg::SYNC_RST[g];
          sync[g] <= cati_pkg::SYNC_RST[g];
          hist[g] <= cati_pkg::SYNC_RST[g];
        end else if (ce) begin
          meta[g] <= trig.raw[g];
          sync[g] <= meta[g];
          hist[g] <= sync[g];
        end
      end
      // One falling edge gives one single-cycle event
      assign fall[g] = hist[g] & ~sync[g] & ce;
    end
  endgenerate

  assign trig.which = fall;
  assign trig.fire = |fall;

  chk_one_per_edge: assert property (@(posedge clk) disable iff (srst)
    trig.fire |=> !trig.fire)
    else $error("trigger event lasted more than one cycle");
endmodule

// >>> rtl/cati_top.sv
// Camera auxiliary trigger, strobe, echo and framing output logic
`timescale 1ns/100ps
module cati_top (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // External trigger inputs
  input wire logic trig_se_in,
  input wire logic trig_diff_p,
  input wire logic trig_diff_n,
  input wire logic cc1_in,
  // Sequencer status
  input wire logic overlap_mode,
  input wire logic sensor_exposing,
  input wire logic line_pixels_valid,
  input wire logic frame_lines_active,
  // Request to the sequencer
  output logic exposure_start,
  // Auxiliary outputs
  output logic strobe_out,
  output logic trig_echo_out,
  output logic line_window_out,
  output logic frame_window_out
);
  // ==========================================
  // Source combination
  cati_trig_if trig ();
  // Differential level is high when P is above N
  wire diff_level = trig_diff_p & ~trig_diff_n;
  assign trig.raw = {cc1_in, diff_level, trig_se_in};

  cati_edge_det u_det (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .trig(trig)
  );

  assign exposure_start = trig.fire;

  // ==========================================
  // Echo pulse
  // A new edge during a pulse restarts the full width, so the echo never
  // truncates; closely spaced triggers merge into one longer pulse.
  cati_pkg::cati_echo_t state;
  cati_pkg::cati_echo_t next_state;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  wire cnt_done = (cnt == cati_pkg::ECHO_CYCLES - 8'h01);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      cati_pkg::CATI_IDLE: begin
        if (trig.fire) begin
          next_state = cati_pkg::CATI_PULSE;
          next_cnt = cati_pkg::ECHO_CNT_RST;
        end
      end
      cati_pkg::CATI_PULSE: begin
        if (trig.fire) begin
          next_cnt = cati_pkg::ECHO_CNT_RST;
        end else if (cnt_done) begin
          next_state = cati_pkg::CATI_IDLE;
          next_cnt = cati_pkg::ECHO_CNT_RST;
        end else begin
          next_cnt = cnt + 8'h01;
        end
      end
      default: begin
        next_state = cati_pkg::CATI_IDLE;
        next_cnt = cati_pkg::ECHO_CNT_RST;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= cati_pkg::CATI_IDLE;
      cnt <= cati_pkg::ECHO_CNT_RST;
    end else if (ce) begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // ==========================================
  // Registered outputs
  wire next_echo = (next_state == cati_pkg::CATI_PULSE);
  wire next_strobe = overlap_mode & sensor_exposing;

  always_ff @(posedge clk) begin
    if (srst) begin
      trig_echo_out <= 1'b0;
      strobe_out <= 1'b0;
      line_window_out <= 1'b0;
      frame_window_out <= 1'b0;
    end else if (ce) begin
      trig_echo_out <= next_echo;
      strobe_out <= next_strobe;
      line_window_out <= line_pixels_valid & frame_lines_active;
      frame_window_out <= frame_lines_active;
    end
  end

  // ==========================================
  // Checks
  sequence s_edge;
    trig.fire && ce;
  endsequence

  sequence s_pulse_held;
    trig_echo_out [*8];
  endsequence

  logic [7:0] hi_cnt;
  always_ff @(posedge clk) begin
    if (srst) begin
      hi_cnt <= 8'h00;
    end else if (ce) begin
      hi_cnt <= (next_echo && !trig.fire) ? hi_cnt + 8'h01 : 8'h00;
    end
  end

  chk_echo_launch: assert property (@(posedge clk) disable iff (srst)
    s_edge |=> trig_echo_out)
    else $error("echo did not start after trigger edge");
  chk_echo_held: assert property (@(posedge clk) disable iff (srst)
    s_edge |=> s_pulse_held)
    else $error("echo pulse too short");
  chk_echo_width: assert property (@(posedge clk) disable iff (srst)
    hi_cnt < cati_pkg::ECHO_CYCLES)
    else $error("echo pulse longer than 6 us");
  chk_echo_ends: assert property (@(posedge clk) disable iff (srst)
    (ce && trig_echo_out && $stable(trig_echo_out) && !trig.fire && cnt_done
     && state == cati_pkg::CATI_PULSE) |=> !trig_echo_out || !ce)
    else $error("echo did not end after its width");
  chk_strobe_follows: assert property (@(posedge clk) disable iff (srst)
    ce |=> strobe_out == $past(overlap_mode & sensor_exposing))
    else $error("strobe does not track exposure");
  chk_line_gap: assert property (@(posedge clk) disable iff (srst)
    (ce && !frame_lines_active) |=> !line_window_out)
    else $error("line window high between frames");
  chk_line_valid: assert property (@(posedge clk) disable iff (srst)
    (ce && line_pixels_valid && frame_lines_active) |=> line_window_out)
    else $error("line window low during valid pixels");
  chk_frame_window: assert property (@(posedge clk) disable iff (srst)
    ce |=> frame_window_out == $past(frame_lines_active))
    else $error("frame window does not track active lines");

  // ==========================================
  // Source, echo, strobe and framing checks
  // A start is only traced back to its edge when the enable stood high
  // through the whole synchroniser path; a frozen edge is reported late.
  sequence s_start_run;
    exposure_start && $past(ce) && $past(ce, 2) && $past(ce, 3);
  endsequence

  sequence s_retrig;
    trig.fire && ce && trig_echo_out;
  endsequence

  sequence s_restarted;
    trig_echo_out && (cnt == cati_pkg::ECHO_CNT_RST);
  endsequence

  sequence s_quiet;
    ce && !trig.fire && (state == cati_pkg::CATI_IDLE);
  endsequence

  chk_start_source: assert property (@(posedge clk) disable iff (srst)
    s_start_run |-> (($past(trig.raw, 3) & ~$past(trig.raw, 2)) != 3'h0))
    else $error("exposure request without a falling edge");

  chk_start_once: assert property (@(posedge clk) disable iff (srst)
    exposure_start |=> !exposure_start)
    else $error("exposure request lasted more than one cycle");

  chk_echo_restart: assert property (@(posedge clk) disable iff (srst)
    s_retrig |=> s_restarted)
    else $error("echo width not restarted by new edge");

  chk_echo_quiet: assert property (@(posedge clk) disable iff (srst)
    s_quiet |=> !trig_echo_out)
    else $error("echo without a trigger edge");

  chk_freeze_hold: assert property (@(posedge clk) disable iff (srst)
    !ce |=> $stable(trig_echo_out) && $stable(state) && $stable(cnt))
    else $error("echo state moved while frozen");

  chk_reset_quiet: assert property (@(posedge clk)
    srst |=> !trig_echo_out && !strobe_out && !line_window_out && !frame_window_out)
    else $error("outputs not low after reset");

  chk_strobe_low: assert property (@(posedge clk) disable iff (srst)
    (ce && !overlap_mode) |=> !strobe_out)
    else $error("strobe high outside overlapped mode");

  chk_frame_low: assert property (@(posedge clk) disable iff (srst)
    (ce && !frame_lines_active) |=> !frame_window_out)
    else $error("frame window high between frames");

  chk_line_low: assert property (@(posedge clk) disable iff (srst)
    (ce && !line_pixels_valid) |=> !line_window_out)
    else $error("line window high in line gap");
endmodule

// >>> test/cati_src_model.sv
// Model of the external trigger equipment on the three trigger sources
`timescale 1ns/100ps
module cati_src_model (
  // Clock
  input wire logic clk,
  // Trigger lines
  output logic trig_se_in,
  output logic trig_diff_p,
  output logic trig_diff_n,
  output logic cc1_in
);
  // Every source idles high (trig_diff_n idles low), so only a deliberate fall requests
  initial begin
    trig_se_in = 1'b1;
    trig_diff_p = 1'b1;
    trig_diff_n = 1'b0;
    cc1_in = 1'b1;
  end
  task automatic set_src(input int s, input logic lvl);
    @(negedge clk);
    case (s)
      0: trig_se_in = lvl;
      1: begin
        trig_diff_p = lvl;
        trig_diff_n = ~lvl;
      end
      default: cc1_in = lvl;
    endcase
  endtask
endmodule

// >>> test/tb.sv
// Self-checking testbench for the camera trigger and timing block
`timescale 1ns/100ps
module tb;
  logic clk, srst, ce, ovl, expo, pix, act, t_se, t_p, t_n, t_cc, start, strobe, echo, lwin, fwin;
  int n_fail = 0;
  int check_count = 0;
  cati_src_model src (.clk(clk), .trig_se_in(t_se), .trig_diff_p(t_p), .trig_diff_n(t_n),
    .cc1_in(t_cc));
  cati_top dut (.clk(clk), .srst(srst), .ce(ce), .trig_se_in(t_se), .trig_diff_p(t_p),
    .trig_diff_n(t_n), .cc1_in(t_cc), .overlap_mode(ovl), .sensor_exposing(expo),
    .line_pixels_valid(pix), .frame_lines_active(act), .exposure_start(start),
    .strobe_out(strobe), .trig_echo_out(echo), .line_window_out(lwin),
    .frame_window_out(fwin));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t output %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      n_fail++;
      $display("ERROR %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One fall must give one start and a 6 us echo; the rise gives nothing
  task automatic trig_one(input int s);
    int starts, width;
    starts = 0;
    width = 0;
    src.set_src(s, 1'b0);
    repeat (200) begin
      @(negedge clk);
      starts += int'(start === 1'b1);
      width += int'(echo === 1'b1);
    end
    src.set_src(s, 1'b1);
    repeat (8) begin
      @(negedge clk);
      starts += int'(start === 1'b1);
    end
    chk_cnt(starts, 1);
    chk_cnt(width, 6000 / 40);
  endtask
  // Freeze defers the start and holds the echo; frozen cycles do not count
  task automatic freeze_test();
    int starts, width;
    starts = 0;
    width = 0;
    src.set_src(0, 1'b0);
    ce = 1'b0;
    repeat (10) begin
      @(negedge clk);
      starts += int'(start === 1'b1);
    end
    chk_bit(echo, 1'b0);
    ce = 1'b1;
    repeat (50) begin
      @(negedge clk);
      starts += int'(start === 1'b1);
      width += int'(echo === 1'b1);
    end
    ce = 1'b0;
    repeat (10) @(negedge clk);
    chk_bit(echo, 1'b1);
    ce = 1'b1;
    repeat (150) begin
      @(negedge clk);
      starts += int'(start === 1'b1);
      width += int'(echo === 1'b1);
    end
    src.set_src(0, 1'b1);
    repeat (8) @(negedge clk);
    chk_cnt(starts, 1);
    chk_cnt(width, 6000 / 40);
  endtask
  // Reset in mid-pulse clears the echo and the quiet line gives no start
  task automatic reset_test();
    int starts;
    starts = 0;
    src.set_src(1, 1'b0);
    repeat (20) @(negedge clk);
    srst = 1'b1;
    src.set_src(1, 1'b1);
    repeat (2) @(negedge clk);
    srst = 1'b0;
    chk_bit(echo, 1'b0);
    repeat (8) begin
      @(negedge clk);
      starts += int'(start === 1'b1);
    end
    chk_bit(echo, 1'b0);
    chk_cnt(starts, 0);
  endtask
  // Drive sequencer status, then look one cycle later
  task automatic seq(input logic [3:0] v, input logic s, input logic l, input logic f);
    {ovl, expo, pix, act} = v;
    @(negedge clk);
    chk_bit(strobe, s);
    chk_bit(lwin, l);
    chk_bit(fwin, f);
  endtask
  task automatic framing_test();
    seq(4'hF, 1'b1, 1'b1, 1'b1);
    seq(4'h7, 1'b0, 1'b1, 1'b1);
    seq(4'hD, 1'b1, 1'b0, 1'b1);
    seq(4'hE, 1'b1, 1'b0, 1'b0);
    seq(4'h0, 1'b0, 1'b0, 1'b0);
  endtask
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    {ovl, expo, pix, act} = 4'h0;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    chk_bit(echo, 1'b0);
    for (int s = 0; s < 3; s++) begin
      trig_one(s);
    end
    framing_test();
    freeze_test();
    reset_test();
    tally_and_finish();
  end
  // Tests need about 1000 cycles; give generous headroom
  initial begin
    #(3000 * 40);
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
